/* File: bench/fcs_cmd_fsm_monitor.sv */
/* Checker for fcs_cmd_fsm, seeing its ports only.
   Assumes one clock domain; bound to the top module. */
`timescale 1ns/1ps
`default_nettype none
module fcs_cmd_fsm_monitor
  import fcs_pkg::*;
#(parameter int ADDR_W = 23, parameter int BLK_LSB = 16, parameter int OP_CYCLES = 16) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Command port
  input wire logic cmdWr,
  input wire logic [7:0] cmdData,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic eraseSuspended,
  // Outputs
  input wire fcs_state_t bankState_r,
  input wire fcs_rdmode_t readMode_r,
  input wire logic [7:0] status_r,
  input wire logic progPulse_r,
  input wire logic [15:0] progData_r,
  input wire logic [ADDR_W-1:0] progAddr_r
);
  // ==========================================================
  // Helpers: addresses that later writes are compared with
  logic [ADDR_W-1:0] firstAddr_r;
  logic [ADDR_W-1:0] bpAddr_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      firstAddr_r <= '0;
    else if (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_SETUP && cmdWr)
      firstAddr_r <= cmdAddr;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      bpAddr_r <= '0;
    else if (bankState_r == ST_ES_IDLE && cmdWr && cmdData == CMD_BUF_PROG)
      bpAddr_r <= cmdAddr;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  reset_ready_a: assert property ($rose(rst_n) |-> bankState_r == ST_READY &&
    readMode_r == RD_ARRAY) else $error("not ready after reset");
  blank_go_a: assert property (bankState_r == ST_BLANK_SETUP && cmdWr &&
    cmdData == CMD_BLANK_CONF |=> bankState_r == ST_BLANK_BUSY) else $error("blank start");
  blank_bad_a: assert property (bankState_r == ST_BLANK_SETUP && cmdWr &&
    cmdData != CMD_BLANK_CONF |=> bankState_r == ST_READY && status_r[5]) else $error("blank err");
  buffered_factory_program_bad_a: assert property (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_SETUP && cmdWr &&
    cmdData != CMD_CONFIRM |=> bankState_r == ST_READY && status_r[4]) else $error("buffered_factory_program err");
  buffered_factory_program_gate_a: assert property (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_SETUP && cmdWr && cmdData == CMD_CONFIRM
    |=> (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY) == !$past(status_r[0])) else $error("buffered_factory_program gate");
  buffered_factory_program_data_a: assert property (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY && cmdWr && cmdAddr != firstAddr_r
    |=> progPulse_r && progData_r == {8'h00, $past(cmdData)}) else $error("buffered_factory_program data");
  buffered_factory_program_exit_a: assert property (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY && cmdWr &&
    cmdAddr == firstAddr_r |=> bankState_r == ST_READY) else $error("buffered_factory_program exit");
  busy_ignore_a: assert property (bankState_r == ST_BLANK_BUSY && cmdWr |=>
    bankState_r inside {ST_BLANK_BUSY, ST_READY} && $stable(status_r[5:4])) else $error("busy");
  clear_kept_a: assert property (bankState_r == ST_ES_IDLE && cmdWr &&
    cmdData == CMD_CLEAR_STATUS |=> $stable(status_r[5:4])) else $error("clear in suspend");
  clear_done_a: assert property (bankState_r == ST_READY && !eraseSuspended && cmdWr &&
    cmdData == CMD_CLEAR_STATUS |=> (status_r & STATUS_ERR_MASK) == 8'h00) else $error("clear");
  bp_block_a: assert property (bankState_r inside {ST_ES_BP_LOAD2, ST_ES_BP_CONF} && cmdWr &&
    cmdAddr[ADDR_W-1:BLK_LSB] != bpAddr_r[ADDR_W-1:BLK_LSB] |=> status_r[4]) else $error("bp blk");
  blank_c: cover property (bankState_r == ST_BLANK_BUSY);
  buffered_factory_program_c: cover property (progPulse_r);
  es_c: cover property (bankState_r == ST_ES_BP_CONF);
  susp_is_c: cover property (bankState_r == ST_ES_BP_SUSP_IS);
endmodule : fcs_cmd_fsm_monitor
bind fcs_cmd_fsm fcs_cmd_fsm_monitor #(.ADDR_W(ADDR_W), .BLK_LSB(BLK_LSB),
  .OP_CYCLES(OP_CYCLES)) u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .cmdWr(cmdWr),
  .cmdData(cmdData), .cmdAddr(cmdAddr), .eraseSuspended(eraseSuspended),
  .bankState_r(bankState_r), .readMode_r(readMode_r), .status_r(status_r),
  .progPulse_r(progPulse_r), .progData_r(progData_r), .progAddr_r(progAddr_r));
`default_nettype wire

/* File: bench/fcs_host_model.sv */
/* Host that issues command cycles to the flash command machine.
   Assumes the caller waits for the returned task before the next write. */
`timescale 1ns/1ps
`default_nettype none
module fcs_host_model #(parameter int ADDR_W = 23) (
  // Clock
  input wire logic sys_clk,
  // Command cycles
  output var logic cmdWr,
  output var logic [7:0] cmdData,
  output var logic [ADDR_W-1:0] cmdAddr
);
  initial begin
    cmdWr = 1'b0;
    cmdData = 8'h00;
    cmdAddr = '0;
  end
  // ==========================================================
  // Outside the strobe the lines carry inverted junk, never old values
  task automatic wr(input logic [7:0] d, input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    cmdWr <= 1'b1;
    cmdData <= d;
    cmdAddr <= a;
    @(posedge sys_clk);
    cmdWr <= 1'b0;
    cmdData <= ~d;
    cmdAddr <= ~a;
    #1;
  endtask : wr
  task automatic wr2(input logic [7:0] d1, input logic [7:0] d2, input logic [ADDR_W-1:0] a);
    wr(d1, a);
    wr(d2, a);
  endtask : wr2
endmodule : fcs_host_model
`default_nettype wire

/* File: bench/flash_command_state_machine_test.sv */
/* Self-checking bench for fcs_cmd_fsm.
   Assumes the host model drives all command cycles. */
`timescale 1ns/1ps
`default_nettype none
module flash_command_state_machine_test
  import fcs_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic eraseSuspended = 1'b0;
  logic cmdWr;
  logic [7:0] cmdData;
  logic [22:0] cmdAddr;
  fcs_state_t bankState_r;
  fcs_rdmode_t readMode_r;
  logic [7:0] status_r;
  logic progPulse_r;
  logic [15:0] progData_r;
  logic [22:0] progAddr_r;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  always #4 sys_clk = ~sys_clk;
  // Long busy count keeps the timer from ending before a test's busy checks
  fcs_cmd_fsm #(.OP_CYCLES(40)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmdWr(cmdWr),
    .cmdData(cmdData), .cmdAddr(cmdAddr), .eraseSuspended(eraseSuspended),
    .bankState_r(bankState_r), .readMode_r(readMode_r), .status_r(status_r),
    .progPulse_r(progPulse_r), .progData_r(progData_r), .progAddr_r(progAddr_r));
  fcs_host_model u_host (.sys_clk(sys_clk), .cmdWr(cmdWr), .cmdData(cmdData), .cmdAddr(cmdAddr));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : chk
  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    eraseSuspended <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(bankState_r, ST_READY, "reset state");
    chk(readMode_r, RD_ARRAY, "reset read mode");
    chk(status_r, STATUS_RESET, "reset status");
  endtask : do_reset
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end
  // ==========================================================
  // Scenarios
  task automatic t_blank();
    int i;
    do_reset();
    u_host.wr2(CMD_BLANK_SETUP, CMD_BLANK_CONF, 23'h0);
    chk(bankState_r, ST_BLANK_BUSY, "blank busy");
    u_host.wr2(CMD_ERASE_SETUP, CMD_CONFIRM, 23'h0);
    chk(bankState_r, ST_BLANK_BUSY, "two-cycle ignored");
    u_host.wr(CMD_READ_ARRAY, 23'h0);
    chk(readMode_r, RD_UNDEF, "read while busy");
    for (i = 0; i < 100 && bankState_r != ST_READY; i++)
      @(posedge sys_clk);
    u_host.wr2(CMD_BLANK_SETUP, CMD_READ_ARRAY, 23'h0);
    chk({bankState_r, status_r[5]}, {ST_READY, 1'b1}, "blank wrong cmd");
    u_host.wr(CMD_CLEAR_STATUS, 23'h0);
    chk(status_r & STATUS_ERR_MASK, 16'h0, "clear");
    u_host.wr(CMD_READ_SIG, 23'h0);
    chk(readMode_r, RD_SIG, "signature mode");
    u_host.wr(CMD_READ_ARRAY, 23'h0);
    chk(readMode_r, RD_ARRAY, "array on idle bank");
    $display("blank check test done");
  endtask : t_blank
  task automatic t_buffered_factory_program();
    do_reset();
    u_host.wr2(CMD_BUFFERED_FACTORY_PROGRAM_SETUP, CMD_CONFIRM, 23'h010004);
    chk(bankState_r, ST_BUFFERED_FACTORY_PROGRAM_BUSY, "factory start");
    u_host.wr(CMD_CLEAR_STATUS, 23'h010006);
    chk({progPulse_r, progData_r}, {1'b1, 16'h0050}, "command taken as data");
    chk(progAddr_r, 23'h010006, "data address");
    chk(bankState_r, ST_BUFFERED_FACTORY_PROGRAM_BUSY, "still busy");
    u_host.wr(8'hA5, 23'h010004);
    chk(bankState_r, ST_READY, "factory exit");
    u_host.wr2(CMD_BUFFERED_FACTORY_PROGRAM_SETUP, CMD_READ_STATUS, 23'h0);
    chk({bankState_r, status_r[4]}, {ST_READY, 1'b1}, "factory wrong cmd");
    u_host.wr(CMD_CLEAR_STATUS, 23'h0);
    chk(status_r[4], 1'b0, "clear before refusal");
    @(posedge sys_clk);
    eraseSuspended <= 1'b1;
    u_host.wr2(CMD_BUFFERED_FACTORY_PROGRAM_SETUP, CMD_CONFIRM, 23'h0);
    chk({bankState_r, status_r[4], status_r[0]}, {ST_READY, 2'b11}, "factory refused");
    @(posedge sys_clk);
    eraseSuspended <= 1'b0;
    $display("factory program test done");
  endtask : t_buffered_factory_program
  task automatic t_es_bp();
    int i;
    do_reset();
    @(posedge sys_clk);
    eraseSuspended <= 1'b1;
    u_host.wr(CMD_READ_STATUS, 23'h0);
    u_host.wr(CMD_BUF_PROG, 23'h0);
    u_host.wr(8'h01, 23'h0);
    u_host.wr(8'h3C, 23'h010000);
    u_host.wr(CMD_CONFIRM, 23'h0);
    chk(status_r[4], 1'b1, "block mismatch");
    u_host.wr(CMD_CLEAR_STATUS, 23'h0);
    chk(status_r[4], 1'b1, "clear kept while suspended");
    u_host.wr(CMD_SUSPEND, 23'h0);
    chk(bankState_r, ST_ES_BP_SUSP, "buffer suspended");
    u_host.wr(CMD_PROG_SETUP_B, 23'h0);
    chk(bankState_r, ST_ES_BP_SUSP_IS, "setup while suspended");
    u_host.wr(8'h00, 23'h0);
    u_host.wr(CMD_CONFIRM, 23'h0);
    chk(bankState_r, ST_ES_BP_BUSY, "resumed");
    for (i = 0; i < 100 && bankState_r != ST_ES_IDLE; i++)
      @(posedge sys_clk);
    u_host.wr(CMD_CLEAR_STATUS, 23'h0);
    chk({bankState_r, status_r[4]}, {ST_ES_IDLE, 1'b1}, "clear kept in suspend idle");
    $display("suspend buffer test done");
  endtask : t_es_bp
  initial begin
    t_blank();
    t_buffered_factory_program();
    t_es_bp();
    give_verdict();
  end
endmodule : flash_command_state_machine_test
`default_nettype wire

/* File: hdl/fcs_busy_timer.sv */
/*
  Operation timer: counts a busy operation down and pulses when done.
  Assumes start is a one-cycle pulse in the sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_busy_timer #(
  parameter int CYCLES = 16
) (
  // Clock and reset
  input wire logic sysClk,
  input wire logic rstN,
  // Control
  input wire logic start,
  input wire logic hold,
  output logic done
);
  // The count register is 16 bits wide
  if (CYCLES < 1 || CYCLES > 65535) begin : g_badCycles
    $error("CYCLES must lie between 1 and 65535");
  end

  logic [15:0] count_r;

  // ==========================================================
  // Countdown; hold freezes it while suspended
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      count_r <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_r <= 16'(CYCLES);
      end else if (count_r != 16'h0000 && !hold) begin
        count_r <= count_r - 16'h0001;
        if (count_r == 16'h0001) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule : fcs_busy_timer
`default_nettype wire

/* File: hdl/fcs_cmd_fsm.sv */
/*
  Command interface state machine for one bank: blank check, buffered
  factory program, and buffer program within erase suspend.
  Assumes command writes arrive as one-cycle strobes synchronous to sys_clk
  and that the host keeps both cycles of a command in one bank.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: Power-up leaves every bank reading the array
// RL2: Array read on busy bank gives undefined data
// RL3: Host keeps both command cycles in one bank
// RL4: Controller active: two-cycle commands are ignored
// RL5: Status clear skipped while busy or suspended
// RL6: Factory program starts only if lowest bit clear
// RL7: Factory busy: writes are data until first address
// RL8: Buffer program fails on differing block address
// RL9: Setup states: confirm proceeds, else ready with error
module fcs_cmd_fsm
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 23,
  parameter int BLK_LSB = 16,
  parameter int OP_CYCLES = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Command write port
  input wire logic cmdWr,
  input wire logic [7:0] cmdData,
  input wire logic [ADDR_W-1:0] cmdAddr,
  // Erase suspend entry from the erase logic outside this block
  input wire logic eraseSuspended,
  // Outputs
  output fcs_state_t bankState_r,
  output fcs_rdmode_t readMode_r,
  output logic [7:0] status_r,
  output logic progPulse_r,
  output logic [15:0] progData_r,
  output logic [ADDR_W-1:0] progAddr_r
);
  if (BLK_LSB >= ADDR_W) begin : g_badBlk
    $error("BLK_LSB must lie inside the address");
  end

  logic rstMeta_r, rstSync_r;
  fcs_state_t state_nxt;
  logic [ADDR_W-BLK_LSB-1:0] firstBlk_r;
  logic [ADDR_W-1:0] befpAddr_r;
  logic timerStart, timerDone, busyState, twoCycleCmd, blkMismatch, esState;

  function automatic logic [ADDR_W-BLK_LSB-1:0] blockOf(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BLK_LSB];
  endfunction : blockOf

  // ==========================================================
  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // ==========================================================
  // Decode
  assign busyState = (bankState_r == ST_BLANK_BUSY) || (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY) ||
                     (bankState_r == ST_ES_BP_BUSY);
  assign twoCycleCmd = (cmdData == CMD_PROG_SETUP_A) || (cmdData == CMD_PROG_SETUP_B) ||
                       (cmdData == CMD_ERASE_SETUP) || (cmdData == CMD_BUFFERED_FACTORY_PROGRAM_SETUP) ||
                       (cmdData == CMD_BLANK_SETUP) || (cmdData == CMD_LOCK_SETUP);
  assign blkMismatch = blockOf(cmdAddr) != firstBlk_r;
  assign esState = bankState_r inside {ST_ES_IDLE, ST_ES_LOCK_SET, ST_ES_BP_LOAD1,
                                       ST_ES_BP_LOAD2, ST_ES_BP_CONF, ST_ES_BP_BUSY,
                                       ST_ES_BP_SUSP, ST_ES_BP_SUSP_IS};
  // Resume from suspend must not reload the count, or suspend would lengthen the job
  assign timerStart = cmdWr && (state_nxt != bankState_r) &&
                      ((state_nxt == ST_BLANK_BUSY) ||
                       (state_nxt == ST_ES_BP_BUSY && bankState_r == ST_ES_BP_CONF));

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = bankState_r;
    if (timerDone && bankState_r == ST_BLANK_BUSY) begin
      state_nxt = ST_READY;
    end else if (timerDone && bankState_r == ST_ES_BP_BUSY) begin
      state_nxt = ST_ES_IDLE;
    end else if (cmdWr) begin
      case (bankState_r)
        ST_READY: begin
          if (cmdData == CMD_BLANK_SETUP) state_nxt = ST_BLANK_SETUP;
          else if (cmdData == CMD_BUFFERED_FACTORY_PROGRAM_SETUP) state_nxt = ST_BUFFERED_FACTORY_PROGRAM_SETUP;
          else if (eraseSuspended) state_nxt = ST_ES_IDLE;
        end
        ST_BLANK_SETUP: begin
          state_nxt = (cmdData == CMD_BLANK_CONF) ? ST_BLANK_BUSY : ST_READY; // RL9
        end
        ST_BLANK_BUSY: state_nxt = ST_BLANK_BUSY; // RL4
        ST_BUFFERED_FACTORY_PROGRAM_SETUP: begin
          if (cmdData == CMD_CONFIRM && !status_r[STATUS_LOWEST_BIT]) begin // RL6
            state_nxt = ST_BUFFERED_FACTORY_PROGRAM_BUSY; // RL9
          end else begin
            state_nxt = ST_READY; // RL9
          end
        end
        ST_BUFFERED_FACTORY_PROGRAM_BUSY: begin
          if (cmdAddr == befpAddr_r) state_nxt = ST_READY; // RL7
        end
        ST_ES_IDLE: begin
          if (cmdData == CMD_BUF_PROG) state_nxt = ST_ES_BP_LOAD1;
          else if (cmdData == CMD_LOCK_SETUP) state_nxt = ST_ES_LOCK_SET;
          else if (cmdData == CMD_CONFIRM) state_nxt = ST_READY;
        end
        ST_ES_LOCK_SET: state_nxt = ST_ES_IDLE;
        ST_ES_BP_LOAD1: state_nxt = ST_ES_BP_LOAD2;
        ST_ES_BP_LOAD2: state_nxt = ST_ES_BP_CONF;
        ST_ES_BP_CONF: begin
          state_nxt = (cmdData == CMD_CONFIRM) ? ST_ES_BP_BUSY : ST_ES_IDLE;
        end
        ST_ES_BP_BUSY: begin
          if (cmdData == CMD_SUSPEND) state_nxt = ST_ES_BP_SUSP;
        end
        ST_ES_BP_SUSP: begin
          if (cmdData == CMD_CONFIRM) state_nxt = ST_ES_BP_BUSY;
          else if (twoCycleCmd) state_nxt = ST_ES_BP_SUSP_IS; // RL4
        end
        ST_ES_BP_SUSP_IS: state_nxt = ST_ES_BP_SUSP; // RL4
        default: state_nxt = ST_READY;
      endcase
    end
  end

  // ==========================================================
  // State register; ready after reset means array reads
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      bankState_r <= ST_READY; // RL1
    end else begin
      bankState_r <= state_nxt; // RL4
    end
  end

  // ==========================================================
  // Read mode
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      readMode_r <= RD_ARRAY; // RL1
    end else if (cmdWr && bankState_r != ST_BUFFERED_FACTORY_PROGRAM_BUSY) begin
      if (cmdData == CMD_READ_ARRAY) begin
        // Busy banks have no meaningful array data to offer
        readMode_r <= busyState ? RD_UNDEF : RD_ARRAY; // RL2
      end else if (cmdData == CMD_READ_SIG || cmdData == CMD_READ_CFI) begin
        readMode_r <= RD_SIG;
      end else begin
        readMode_r <= RD_STATUS;
      end
    end else if (timerDone && readMode_r == RD_UNDEF) begin
      readMode_r <= RD_ARRAY;
    end
  end

  // ==========================================================
  // Address capture for sequence checks
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      firstBlk_r <= '0;
      befpAddr_r <= '0;
    end else if (cmdWr) begin
      if (bankState_r == ST_ES_IDLE && cmdData == CMD_BUF_PROG) firstBlk_r <= blockOf(cmdAddr);
      if (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_SETUP) befpAddr_r <= cmdAddr;
    end
  end

  // ==========================================================
  // Status bits; hardware set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r[STATUS_READY_BIT] <= !busyState;
      // Any erase suspend counts as suspended, so errors survive a clear there
      if (cmdWr && cmdData == CMD_CLEAR_STATUS && !busyState && !esState &&
          !eraseSuspended && bankState_r != ST_BUFFERED_FACTORY_PROGRAM_BUSY) begin
        status_r <= (status_r & ~STATUS_ERR_MASK) | 8'h80; // RL5
      end
      // Lowest bit flags an operation held elsewhere; factory program needs it clear
      status_r[STATUS_LOWEST_BIT] <= eraseSuspended; // RL6
      if (cmdWr && (bankState_r == ST_BLANK_SETUP) && cmdData != CMD_BLANK_CONF) begin
        status_r[STATUS_ERASE_ERR] <= 1'b1; // RL9
      end
      if (cmdWr && bankState_r == ST_BUFFERED_FACTORY_PROGRAM_SETUP &&
          (cmdData != CMD_CONFIRM || status_r[STATUS_LOWEST_BIT])) begin
        status_r[STATUS_PROG_ERR] <= 1'b1; // RL6
      end
      if (cmdWr && bankState_r == ST_ES_LOCK_SET) begin
        status_r[STATUS_LOCK_ERR] <= 1'b1;
      end
      if (cmdWr && (bankState_r == ST_ES_BP_LOAD2 || bankState_r == ST_ES_BP_CONF) &&
          blkMismatch) begin
        status_r[STATUS_PROG_ERR] <= 1'b1; // RL8
      end
      if (cmdWr && bankState_r == ST_ES_BP_CONF && cmdData != CMD_CONFIRM) begin
        status_r[STATUS_PROG_ERR] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Program data path; factory busy treats every write away from the first address as data
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      progPulse_r <= 1'b0;
      progData_r <= 16'h0000;
      progAddr_r <= '0;
    end else begin
      progPulse_r <= cmdWr && (bankState_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY) && (cmdAddr != befpAddr_r); // RL7
      if (cmdWr) begin
        progData_r <= {8'h00, cmdData};
        progAddr_r <= cmdAddr;
      end
    end
  end

  // ==========================================================
  // Busy timing; holds while the buffer program is suspended
  fcs_busy_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .sysClk(sys_clk),
    .rstN(rstSync_r),
    .start(timerStart),
    .hold(bankState_r == ST_ES_BP_SUSP || bankState_r == ST_ES_BP_SUSP_IS),
    .done(timerDone)
  );
endmodule : fcs_cmd_fsm
`default_nettype wire

/* File: hdl/fcs_pkg.sv */
/*
  Package for the flash command state machine: command codes, per-bank
  state encoding, status bit positions and reset values.
  Assumes a single synchronous clock domain and no software registers.
*/
package fcs_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP_A = 8'h10;
  localparam logic [7:0] CMD_PROG_SETUP_B = 8'h40;
  localparam logic [7:0] CMD_BUF_PROG     = 8'hE8;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_BUFFERED_FACTORY_PROGRAM_SETUP   = 8'h80;
  localparam logic [7:0] CMD_BLANK_SETUP  = 8'hBC;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_BLANK_CONF   = 8'hCB;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_SIG     = 8'h90;
  localparam logic [7:0] CMD_READ_CFI     = 8'h98;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;

  // ==========================================================
  // Status bits
  localparam int STATUS_LOWEST_BIT = 0;
  localparam int STATUS_LOCK_ERR   = 1;
  localparam int STATUS_PROG_ERR   = 4;
  localparam int STATUS_ERASE_ERR  = 5;
  localparam int STATUS_READY_BIT  = 7;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] STATUS_ERR_MASK = 8'h3A;

  // ==========================================================
  // Bank states
  typedef enum logic [3:0] {
    ST_READY        = 4'h0,
    ST_BLANK_SETUP  = 4'h1,
    ST_BLANK_BUSY   = 4'h2,
    ST_BUFFERED_FACTORY_PROGRAM_SETUP   = 4'h3,
    ST_BUFFERED_FACTORY_PROGRAM_BUSY    = 4'h4,
    ST_ES_IDLE      = 4'h5,
    ST_ES_LOCK_SET  = 4'h6,
    ST_ES_BP_LOAD1  = 4'h7,
    ST_ES_BP_LOAD2  = 4'h8,
    ST_ES_BP_CONF   = 4'h9,
    ST_ES_BP_BUSY   = 4'hA,
    ST_ES_BP_SUSP   = 4'hB,
    ST_ES_BP_SUSP_IS = 4'hC
  } fcs_state_t;

  // Read modes
  typedef enum logic [1:0] {
    RD_ARRAY  = 2'h0,
    RD_STATUS = 2'h1,
    RD_SIG    = 2'h2,
    RD_UNDEF  = 2'h3
  } fcs_rdmode_t;

endpackage : fcs_pkg
